// ---- logic/trap_wake_intc.v ----
// trap and wake-line interrupt logic with an axi4-lite register slave
// assumes the core gives one-cycle pulses for its instruction events
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`include "trap_wake_consts.vh"
module trap_wake_intc #(
  parameter LINES = 8,
  parameter PC_W = 15
) (
  input wire clk,
  input wire reset_n,
  // core side
  input wire ir_load,
  input wire [7:0] ir_opcode,
  input wire fetch_unmapped,
  input wire [PC_W-1:0] fetch_pc,
  input wire clear_pending_instr,
  input wire vector_dispatch_instr,
  input wire return_from_int_instr,
  input wire return_skip_instr,
  input wire stack_pop,
  input wire [7:0] stack_ptr_after,
  input wire low_power_active,
  input wire other_int_req,
  input wire [7:0] other_vector,
  input wire [LINES-1:0] wake_line,
  output reg trap_take,
  output reg [PC_W-1:0] trap_return_addr,
  output reg maskable_take,
  output reg dispatch_valid,
  output reg [7:0] dispatch_low_byte,
  output reg pc_force,
  output reg [PC_W-1:0] pc_force_value,
  output reg skip_return,
  output reg wake_up,
  output reg wake_int_req,
  output reg trap_lockout,
  // axi4-lite slave
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg trap_pending_flag;
  reg in_maskable;
  reg [LINES-1:0] wake_line_enable_reg;
  reg [LINES-1:0] wake_edge_select_reg;
  reg [LINES-1:0] wake_pending_reg;
  reg global_int_enable;
  reg wake_group_int_enable;
  reg [LINES-1:0] sync_a;
  reg [LINES-1:0] sync_b;
  reg [LINES-1:0] sync_c;
  reg [1:0] sync_fill;
  reg [11:0] aw_addr;
  reg aw_have;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_have;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function is_trap_fetch;
    input load;
    input [7:0] opc;
    input unmapped;
    begin
      // unmapped memory reads as zero, which is the trap opcode
      is_trap_fetch = load & (unmapped | (opc == `OPC_TRAP));
    end
  endfunction

  function [7:0] reg_byte;
    input [7:0] old;
    input [31:0] data;
    input strb0;
    begin
      reg_byte = strb0 ? data[7:0] : old;
    end
  endfunction

  wire trap_now = is_trap_fetch(ir_load, ir_opcode, fetch_unmapped);
  // a pending trap hides every maskable source
  wire mask_open = ~trap_pending_flag & ~in_maskable & global_int_enable;
  wire wake_req = wake_group_int_enable & global_int_enable & (|(wake_pending_reg & wake_line_enable_reg));
  wire mask_req = mask_open & ~trap_now & (wake_req | other_int_req);
  // edge detect on synchronised lines, shared with wakeup
  // no edge counts until the last stage holds a real pin sample
  wire sync_ready = (sync_fill == `SYNC_FULL);
  wire [LINES-1:0] rise = sync_b & ~sync_c & {LINES{sync_ready}};
  wire [LINES-1:0] fall = ~sync_b & sync_c & {LINES{sync_ready}};
  wire [LINES-1:0] edge_hit = (wake_edge_select_reg & fall) | (~wake_edge_select_reg & rise);
  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_have & w_have & ~s_axi_bvalid;
  wire wr_pend = do_write & (aw_addr == `REG_WAKE_PEND) & w_strb[0];
  wire [LINES-1:0] pend_clr = wr_pend ? w_data[LINES-1:0] : {LINES{1'b0}};

  // ---------------------------------------------------------------
  // wake-line synchroniser
  // ---------------------------------------------------------------
  // the reset value of the stages may differ from the idle pin level,
  // so the fill count keeps that difference from posing as an edge
  always @(posedge clk) begin
    if (!reset_n) begin
      sync_a <= {LINES{1'b0}};
      sync_b <= {LINES{1'b0}};
      sync_c <= {LINES{1'b0}};
      sync_fill <= 2'd0;
    end else begin
      sync_a <= wake_line;
      sync_b <= sync_a;
      sync_c <= sync_b;
      if (sync_fill != `SYNC_FULL)
        sync_fill <= sync_fill + 2'd1;
    end
  end

  // ---------------------------------------------------------------
  // wake pending latches
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      wake_pending_reg <= {LINES{1'b0}};
    end else begin
      // a new edge wins over a software clear of the same bit
      wake_pending_reg <= (wake_pending_reg & ~pend_clr) | edge_hit;
    end
  end

  // ---------------------------------------------------------------
  // trap pending and routine state
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      trap_pending_flag <= 1'b0;
      in_maskable <= 1'b0;
    end else begin
      // one bit only: a nested clear releases the outer handler too
      if (trap_now)
        trap_pending_flag <= 1'b1;
      else if (clear_pending_instr)
        trap_pending_flag <= 1'b0;
      if (mask_req)
        in_maskable <= 1'b1;
      else if (return_from_int_instr)
        in_maskable <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // answers to the core
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      trap_take <= 1'b0;
      trap_return_addr <= {PC_W{1'b0}};
      maskable_take <= 1'b0;
      dispatch_valid <= 1'b0;
      dispatch_low_byte <= `VEC_DEFAULT;
      pc_force <= 1'b0;
      pc_force_value <= {PC_W{1'b0}};
      skip_return <= 1'b0;
      wake_up <= 1'b0;
      wake_int_req <= 1'b0;
      trap_lockout <= 1'b0;
    end else begin
      trap_take <= trap_now;
      trap_return_addr <= fetch_pc;
      skip_return <= return_skip_instr;
      maskable_take <= mask_req;
      dispatch_valid <= vector_dispatch_instr;
      if (vector_dispatch_instr) begin
        // only the low byte is produced; the core keeps the high byte
        if (trap_pending_flag)
          dispatch_low_byte <= `VEC_TRAP;
        else if (other_int_req & global_int_enable)
          dispatch_low_byte <= other_vector;
        else if (wake_req)
          dispatch_low_byte <= `VEC_WAKE;
        else
          dispatch_low_byte <= `VEC_DEFAULT;
      end
      pc_force <= stack_pop & (stack_ptr_after < `STACK_LIMIT);
      pc_force_value <= `PC_POP_FAULT;
      // any enabled-line edge ends halt or idle; service only if the request is open
      wake_up <= low_power_active & (|(edge_hit & wake_line_enable_reg));
      wake_int_req <= wake_req;
      trap_lockout <= trap_pending_flag | trap_now;
    end
  end

  // ---------------------------------------------------------------
  // register slave (trap pending has no address)
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      wake_line_enable_reg <= {LINES{1'b0}};
      wake_edge_select_reg <= {LINES{1'b0}};
      global_int_enable <= 1'b0;
      wake_group_int_enable <= 1'b0;
    end else begin
      if (aw_fire) begin
        aw_addr <= s_axi_awaddr;
        aw_have <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (w_fire) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_have <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RESP_OKAY;
        case (aw_addr)
          `REG_WAKE_EN: wake_line_enable_reg <= reg_byte(wake_line_enable_reg, w_data, w_strb[0]);
          `REG_WAKE_EDGE: wake_edge_select_reg <= reg_byte(wake_edge_select_reg, w_data, w_strb[0]);
          `REG_WAKE_PEND: ;
          `REG_CTRL: begin
            if (w_strb[0]) begin
              global_int_enable <= w_data[`CTRL_GIE];
              wake_group_int_enable <= w_data[`CTRL_GROUP];
            end
          end
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        case (s_axi_araddr)
          `REG_WAKE_EN: s_axi_rdata[LINES-1:0] <= wake_line_enable_reg;
          `REG_WAKE_EDGE: s_axi_rdata[LINES-1:0] <= wake_edge_select_reg;
          `REG_WAKE_PEND: s_axi_rdata[LINES-1:0] <= wake_pending_reg;
          `REG_CTRL: s_axi_rdata[1:0] <= {wake_group_int_enable, global_int_enable};
          `REG_STATUS: s_axi_rdata[1:0] <= {wake_req, in_maskable};
          default: s_axi_rresp <= `RESP_SLVERR;
        endcase
      end
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// ---- inc/trap_wake_consts.vh ----
// constants for the trap and wake-line interrupt block
// assumes a register bus of 32-bit aligned words, one clock domain
`ifndef TRAP_WAKE_CONSTS_VH
`define TRAP_WAKE_CONSTS_VH
`define OPC_TRAP 8'h00
`define STACK_LIMIT 8'h6f
`define PC_POP_FAULT 15'h7fff
`define VEC_TRAP 8'hfe
`define VEC_WAKE 8'he2
`define VEC_DEFAULT 8'he0
`define SYNC_FULL 2'd3
`define REG_WAKE_EN 12'h000
`define REG_WAKE_EDGE 12'h004
`define REG_WAKE_PEND 12'h008
`define REG_CTRL 12'h00c
`define REG_STATUS 12'h010
`define CTRL_GIE 0
`define CTRL_GROUP 1
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ---- verification/trap_wake_props.sv ----
// checker for the trap and wake-line interrupt block
// assumes it is bound to trap_wake_intc and watches its ports only
module trap_wake_props #(parameter PC_W = 15) (
  input wire clk, input wire reset_n, input wire ir_load, input wire [7:0] ir_opcode,
  input wire fetch_unmapped, input wire [PC_W-1:0] fetch_pc, input wire clear_pending_instr,
  input wire vector_dispatch_instr, input wire return_skip_instr, input wire stack_pop,
  input wire [7:0] stack_ptr_after, input wire low_power_active, input wire trap_take,
  input wire [PC_W-1:0] trap_return_addr, input wire maskable_take, input wire dispatch_valid,
  input wire [7:0] dispatch_low_byte, input wire pc_force, input wire [PC_W-1:0] pc_force_value,
  input wire skip_return, input wire wake_up, input wire trap_lockout
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_fetch_trap;
    ir_load && (ir_opcode == 8'h00 || fetch_unmapped);
  endsequence
  sequence s_trap_answer;
    trap_take && trap_return_addr == $past(fetch_pc);
  endsequence
  property p_trap; s_fetch_trap |=> s_trap_answer; endproperty
  a_trap: assert property (p_trap) else $error("trap fetch not taken");
  property p_lock; s_fetch_trap |=> trap_lockout; endproperty
  a_lock: assert property (p_lock) else $error("trap fetch did not lock out");
  property p_nomask; trap_lockout |-> !maskable_take; endproperty
  a_nomask: assert property (p_nomask) else $error("maskable taken under trap");
  property p_disp;
    vector_dispatch_instr && trap_lockout && !$past(clear_pending_instr) |=> dispatch_valid && dispatch_low_byte == 8'hfe;
  endproperty
  a_disp: assert property (p_disp) else $error("dispatch missed trap vector");
  property p_pop; stack_pop && stack_ptr_after < 8'h6f |=> pc_force && pc_force_value == 15'h7fff; endproperty
  a_pop: assert property (p_pop) else $error("stack underflow not forced");
  property p_clr; clear_pending_instr && !ir_load ##1 !ir_load |=> !trap_lockout; endproperty
  a_clr: assert property (p_clr) else $error("pending clear ignored");
  property p_skip; return_skip_instr |=> skip_return; endproperty
  a_skip: assert property (p_skip) else $error("skip return missing");
  property p_wake; wake_up |-> $past(low_power_active); endproperty
  a_wake: assert property (p_wake) else $error("wake outside low power");
endmodule
bind trap_wake_intc trap_wake_props #(.PC_W(PC_W)) u_props (.*);

// ---- verification/core_model.sv ----
// behavioural model of the core fetch stage
// assumes the bench asks for one fetch at a time, one cycle each
module core_model (
  input wire clk, input wire fetch_req, input wire [7:0] mem_op, input wire mem_missing,
  input wire [14:0] req_pc, output reg ir_load, output reg [7:0] ir_opcode,
  output reg fetch_unmapped, output reg [14:0] fetch_pc
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ir_load = 1'b0;
    ir_opcode = 8'h5a;
    fetch_unmapped = 1'b0;
    fetch_pc = 15'h0;
  end
  always @(posedge clk) begin
    ir_load <= fetch_req;
    fetch_unmapped <= fetch_req && mem_missing;
    fetch_pc <= fetch_req ? req_pc : ~fetch_pc;
    // missing memory reads back as zeros; idle opcode toggles
    ir_opcode <= !fetch_req ? ~ir_opcode : (mem_missing ? 8'h00 : mem_op);
  end
endmodule

// ---- verification/test_trap_and_wake_port_interrupts.sv ----
// self-checking bench for the trap and wake-line interrupt block
// assumes core_model drives the fetch side and the checker is bound in
`include "trap_wake_consts.vh"
module test_trap_and_wake_port_interrupts;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, ir_load, fetch_unmapped, clear_pending_instr, vector_dispatch_instr, return_from_int_instr;
  logic return_skip_instr, stack_pop, low_power_active, other_int_req, trap_take, maskable_take, dispatch_valid;
  logic pc_force, skip_return, wake_up, wake_int_req, trap_lockout, fetch_req, mem_missing;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [3:0] s_axi_wstrb;
  logic [7:0] ir_opcode, stack_ptr_after, other_vector, wake_line, dispatch_low_byte, mem_op;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [14:0] fetch_pc, trap_return_addr, pc_force_value, req_pc;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  int failures, n_tests, seen;
  trap_wake_intc #(.LINES(8), .PC_W(15)) dut (.*);
  core_model partner (.*);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task end_sim;
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
    if (i == 40) begin failures++; end_sim; end
  endtask
  task rdr(input logic [11:0] a);
    int i;
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    {rd, resp} = {s_axi_rdata, s_axi_rresp};
    if (i == 40) begin failures++; end_sim; end
  endtask
  // one-cycle core strobes, then wait for the answer to land
  task step(input logic f, c, v, k, p, input int lat);
    @(posedge clk);
    {fetch_req, clear_pending_instr, vector_dispatch_instr, return_skip_instr, stack_pop} <= {f, c, v, k, p};
    @(posedge clk);
    {fetch_req, clear_pending_instr, vector_dispatch_instr, return_skip_instr, stack_pop} <= 5'h0;
    repeat (lat - 1) @(posedge clk);
    #1;
  endtask
  task t_trap;
    {mem_op, req_pc} = {8'h3c, 15'h1234};
    step(1, 0, 0, 0, 0, 2);
    chk(trap_take, 0);
    mem_op = 8'h00;
    step(1, 0, 0, 0, 0, 2);
    chk({trap_take, trap_lockout, trap_return_addr}, {2'b11, 15'h1234});
    step(0, 0, 1, 0, 0, 1);
    chk(dispatch_low_byte, 8'hfe);
    step(0, 1, 0, 0, 0, 2);
    chk(trap_lockout, 0);
    step(0, 0, 1, 0, 0, 1);
    chk(dispatch_low_byte, 8'he0);
  endtask
  task t_nest;
    {mem_missing, mem_op} = {1'b1, 8'hff};
    step(1, 0, 0, 0, 0, 2);
    chk(trap_take, 1);
    step(1, 0, 0, 0, 0, 2);
    chk(trap_take, 1);
    step(0, 1, 0, 0, 0, 2);
    chk(trap_lockout, 0);
    mem_missing = 1'b0;
  endtask
  task t_pop;
    stack_ptr_after <= 8'h6e;
    step(0, 0, 0, 0, 1, 1);
    chk({pc_force, pc_force_value}, 16'hffff);
    stack_ptr_after <= 8'h6f;
    step(0, 0, 0, 1, 1, 1);
    chk({pc_force, skip_return}, 2'b01);
  endtask
  task t_wake;
    wr(`REG_WAKE_EN, 32'h8);
    wr(`REG_WAKE_EDGE, 32'h8);
    wr(`REG_CTRL, 32'h3);
    @(posedge clk) wake_line <= 8'hf7;
    repeat (8) @(posedge clk);
    rdr(`REG_WAKE_PEND);
    #1;
    chk({rd, wake_int_req}, {32'h8, 1'b1});
    rdr(`REG_STATUS);
    chk(rd, 32'h3);
    step(0, 0, 1, 0, 0, 1);
    chk({dispatch_valid, dispatch_low_byte}, {1'b1, 8'he2});
    wr(`REG_CTRL, 32'h1);
    @(posedge clk) wake_line <= 8'hff;
    repeat (8) @(posedge clk);
    #1;
    chk(wake_int_req, 0);
    wr(`REG_WAKE_PEND, 32'h8);
    rdr(`REG_WAKE_PEND);
    chk(rd, 32'h0);
    rdr(12'h014);
    chk(resp, 2'b10);
  endtask
  task t_sleep;
    seen = 0;
    @(posedge clk) low_power_active <= 1'b1;
    @(posedge clk) wake_line <= 8'hf7;
    repeat (10) begin
      @(posedge clk);
      #1;
      seen += wake_up;
    end
    chk(seen, 1);
    @(posedge clk) low_power_active <= 1'b0;
  endtask
  initial begin
    reset_n = 1'b0;
    {fetch_req, clear_pending_instr, vector_dispatch_instr, return_skip_instr, stack_pop} = 5'h0;
    {return_from_int_instr, other_int_req, other_vector, low_power_active, mem_missing} = 12'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {24'h0, 32'h0, 4'hf};
    {stack_ptr_after, wake_line, mem_op, req_pc} = {8'h80, 8'hff, 8'h0, 15'h0};
    {failures, n_tests} = {32'h0, 32'h0};
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    t_trap;
    t_nest;
    t_pop;
    t_wake;
    t_sleep;
    end_sim;
  end
endmodule
